// ===== hdl/sbh_pkg.sv
// Purpose: shared constants and types for the backplane host address interface
// Assumes: 32-bit APB register access, one processor-side request port
// Notes: offsets are byte addresses of aligned words
package sbh_pkg;

	// register byte offsets
	localparam logic [7:0] OFF_MMU = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_IOBASE = 8'h08;
	localparam logic [7:0] OFF_SOCKET = 8'h0c;
	localparam logic [7:0] OFF_STATUS = 8'h10;

	// mmu field positions
	localparam int MMU_BANK_START_LSB = 0;
	localparam int MMU_COMMON_START_LSB = 4;
	localparam int MMU_BANK_BASE_LSB = 8;
	localparam int MMU_COMMON_BASE_LSB = 16;

	// control field positions
	localparam int CTRL_MEM_WAIT_LSB = 0;
	localparam int CTRL_IO_WAIT_LSB = 4;
	localparam int CTRL_REFRESH_EN_BIT = 8;
	localparam int CTRL_TIMER_TOGGLE_OUTPUT_EN_BIT = 9;

	// socket field positions (socket n at n * SOCK_STRIDE)
	localparam int SOCK_BASE_LSB = 0;
	localparam int SOCK_SIZE_LSB = 4;
	localparam int SOCK_STRIDE = 8;

	// reset values
	localparam logic [31:0] RST_MMU = 32'h0000_00ff;
	localparam logic [1:0] RST_MEM_WAIT = 2'h3;
	localparam logic [2:0] RST_IO_WAIT = 3'h6;
	localparam logic RST_REFRESH_EN = 1'b1;
	localparam logic RST_TIMER_TOGGLE_OUTPUT_EN = 1'b0;
	localparam logic [9:0] RST_IO_BASE = 10'h000;
	localparam logic [15:0] RST_SOCKET = 16'h2200;

	// limits and timing counts
	localparam logic [2:0] IO_WAIT_MAX = 3'h6;
	localparam int ADDR_PHASE_CYCLES = 1;
	localparam int REFRESH_CYCLES = 1;

	// socket size codes
	localparam logic [1:0] SOCK_8K = 2'h0;
	localparam logic [1:0] SOCK_16K = 2'h1;
	localparam logic [1:0] SOCK_32K = 2'h2;

	typedef enum logic [1:0] {
		CYC_MEM = 2'h0,
		CYC_IO = 2'h1,
		CYC_INTACK = 2'h2
	} sbh_kind_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_WAIT = 3'h2,
		ST_DATA = 3'h3,
		ST_REFR = 3'h4
	} sbh_state_t;

	typedef struct packed {
		logic valid;
		sbh_kind_t kind;
		logic write;
		logic fetch;
		logic dma;
		logic [15:0] addr;
		logic [7:0] wdata;
	} sbh_req_t;

	typedef struct packed {
		logic done;
		logic internal_io;
		logic socket_hit;
		logic [7:0] rdata;
	} sbh_resp_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] data;
		logic data_oe_n;
		logic mem_rq_n;
		logic io_rq_n;
		logic rd_n;
		logic wr_n;
		logic mem_sync_n;
		logic refresh_n;
		logic intack_n;
		logic [1:0] sock_cs_n;
		logic memex;
		logic ioexp;
	} sbh_bp_t;

endpackage

// ===== hdl/sbh_host_if.sv
// Purpose: backplane host address interface with mmu, wait states and refresh
// Assumes: one clock pclk, backplane data inputs asynchronous to it
// Notes: registers reached over apb; no interrupt logic of its own
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - map 16-bit logical address through bank/common areas
// - present 20-bit multiplexed physical memory address
// - physical bits 0-15 drive address lines directly
// - bits 16-19 multiplexed onto data lines 0-3
// - physical bit 19 always driven low
// - timer toggle enabled kills address bit 18
// - insert zero to three memory wait states
// - insert zero to six io wait states
// - generate refresh strobe, software can disable it
// - memory expansion line held at ground
// - io expansion line held at ground
// - io cycles carry full 16-bit address
// - internal io block relocatable on 64-byte boundary
// - sockets decode in low 64K, 8K/16K/32K sizes
// - socket base selectable on 8K boundary
// - bidirectional data path for dma to sockets
// - mode 2 acknowledge reads vector from card
// - supply fault holds reset and blocks writes
module sbh_host_if (
	// apb clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// processor request port
	input wire sbh_pkg::sbh_req_t cpu_req,
	output logic cpu_ready,
	output sbh_pkg::sbh_resp_t cpu_resp,
	// on-chip timer toggle
	input wire logic timer_toggle_output,
	output logic timer_output_pin,
	// backplane pins
	output sbh_pkg::sbh_bp_t bp_out,
	input wire logic [7:0] bp_data_in,
	// supply monitor
	input wire logic supply_fault,
	output logic sys_reset_n
);

	// register state
	logic [31:0] mmu_reg;
	logic [1:0] mem_wait_reg;
	logic [2:0] io_wait_reg;
	logic refresh_en_reg;
	logic timer_toggle_output_en_reg;
	logic [9:0] io_base_reg;
	logic [15:0] socket_reg;

	// synchronisers
	logic [7:0] din_meta_reg;
	logic [7:0] din_reg;
	logic fault_meta_reg;
	logic fault_reg;

	// cycle state
	sbh_pkg::sbh_state_t state_reg;
	sbh_pkg::sbh_state_t state_next;
	logic [2:0] wait_cnt_reg;
	sbh_pkg::sbh_req_t cur_reg;
	logic [19:0] phys_reg;
	logic [1:0] hit_reg;
	logic [7:0] refresh_row_reg;
	sbh_pkg::sbh_bp_t bp_next;

	// decoded request
	logic [19:0] phys_calc;
	logic [19:0] phys_sel;
	logic [1:0] hit_calc;
	logic io_internal;
	logic take;

	// socket hit: window of 1, 2 or 4 eight-kilobyte pages from the base
	function automatic logic sock_hit(input logic [19:0] pa, input logic [2:0] base,
		input logic [1:0] size);
		logic [2:0] off;
		logic [3:0] pages;
		off = 3'(pa[15:13] - base);
		case (size)
			sbh_pkg::SOCK_8K: pages = 4'h1;
			sbh_pkg::SOCK_16K: pages = 4'h2;
			sbh_pkg::SOCK_32K: pages = 4'h4;
			default: pages = 4'h0;
		endcase
		sock_hit = (pa[19:16] == 4'h0) && ({1'b0, off} < pages);
	endfunction

	always_comb begin
		logic [3:0] page;
		logic [7:0] base;
		page = cpu_req.addr[15:12];
		base = 8'h00;
		if (page >= mmu_reg[sbh_pkg::MMU_COMMON_START_LSB +: 4]) begin
			base = mmu_reg[sbh_pkg::MMU_COMMON_BASE_LSB +: 8];
		end else if (page >= mmu_reg[sbh_pkg::MMU_BANK_START_LSB +: 4]) begin
			base = mmu_reg[sbh_pkg::MMU_BANK_BASE_LSB +: 8];
		end
		phys_calc = {8'(base + {4'h0, page}), cpu_req.addr[11:0]};
		phys_calc[19] = 1'b0;
		// bit 18 lost to timer pin
		if (timer_toggle_output_en_reg) begin
			phys_calc[18] = 1'b0;
		end
	end

	generate
		for (genvar s = 0; s < 2; s++) begin : g_sock
			assign hit_calc[s] = (cpu_req.kind == sbh_pkg::CYC_MEM) && sock_hit(phys_calc,
				socket_reg[s*sbh_pkg::SOCK_STRIDE + sbh_pkg::SOCK_BASE_LSB +: 3],
				socket_reg[s*sbh_pkg::SOCK_STRIDE + sbh_pkg::SOCK_SIZE_LSB +: 2]);
		end
	endgenerate

	assign io_internal = (cpu_req.kind == sbh_pkg::CYC_IO) && (cpu_req.addr[15:6] == io_base_reg);

	assign phys_sel = (cpu_req.kind == sbh_pkg::CYC_MEM) ? phys_calc : {4'h0, cpu_req.addr};

	assign cpu_ready = (state_reg == sbh_pkg::ST_IDLE) && !fault_reg;
	assign take = cpu_ready && cpu_req.valid;

	// backplane input synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_meta_reg <= 8'h00;
			din_reg <= 8'h00;
			fault_meta_reg <= 1'b1;
			fault_reg <= 1'b1;
		end else begin
			din_meta_reg <= bp_data_in;
			din_reg <= din_meta_reg;
			fault_meta_reg <= supply_fault;
			fault_reg <= fault_meta_reg;
		end
	end

	// reset held while supply is out of tolerance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_reset_n <= 1'b0;
		end else begin
			sys_reset_n <= !fault_reg;
		end
	end

	// apb register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mmu_reg <= sbh_pkg::RST_MMU;
			mem_wait_reg <= sbh_pkg::RST_MEM_WAIT;
			io_wait_reg <= sbh_pkg::RST_IO_WAIT;
			refresh_en_reg <= sbh_pkg::RST_REFRESH_EN;
			timer_toggle_output_en_reg <= sbh_pkg::RST_TIMER_TOGGLE_OUTPUT_EN;
			io_base_reg <= sbh_pkg::RST_IO_BASE;
			socket_reg <= sbh_pkg::RST_SOCKET;
		end else if (psel && penable && pwrite) begin
			case (paddr)
				sbh_pkg::OFF_MMU: mmu_reg <= {8'h00, pwdata[23:0]};
				sbh_pkg::OFF_CTRL: begin
					mem_wait_reg <= pwdata[sbh_pkg::CTRL_MEM_WAIT_LSB +: 2];
					if (pwdata[sbh_pkg::CTRL_IO_WAIT_LSB +: 3] > sbh_pkg::IO_WAIT_MAX) begin
						io_wait_reg <= sbh_pkg::IO_WAIT_MAX;
					end else begin
						io_wait_reg <= pwdata[sbh_pkg::CTRL_IO_WAIT_LSB +: 3];
					end
					refresh_en_reg <= pwdata[sbh_pkg::CTRL_REFRESH_EN_BIT];
					timer_toggle_output_en_reg <= pwdata[sbh_pkg::CTRL_TIMER_TOGGLE_OUTPUT_EN_BIT];
				end
				sbh_pkg::OFF_IOBASE: io_base_reg <= pwdata[15:6];
				sbh_pkg::OFF_SOCKET: socket_reg <= pwdata[15:0] & 16'h3737;
				default: begin
				end
			endcase
		end
	end

	// apb read path; zero-wait slave, unmapped offsets answer with an error
	assign pready = 1'b1;
	always_comb begin
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		case (paddr)
			sbh_pkg::OFF_MMU: prdata = mmu_reg;
			sbh_pkg::OFF_CTRL: prdata = {22'h0, timer_toggle_output_en_reg, refresh_en_reg, 1'b0,
				io_wait_reg, 2'h0, mem_wait_reg};
			sbh_pkg::OFF_IOBASE: prdata = {16'h0, io_base_reg, 6'h00};
			sbh_pkg::OFF_SOCKET: prdata = {16'h0, socket_reg};
			sbh_pkg::OFF_STATUS: prdata = {fault_reg, 7'h00, 1'b0, state_reg, phys_reg};
			default: pslverr = psel && penable;
		endcase
	end

	// timer pin shares the address bit 18 function
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_output_pin <= 1'b0;
		end else begin
			timer_output_pin <= timer_toggle_output_en_reg && timer_toggle_output;
		end
	end

	// cycle sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sbh_pkg::ST_IDLE: begin
				if (take && !io_internal) begin
					state_next = sbh_pkg::ST_ADDR;
				end
			end
			sbh_pkg::ST_ADDR: begin
				if ((cur_reg.kind == sbh_pkg::CYC_MEM && mem_wait_reg == 2'h0) ||
					(cur_reg.kind != sbh_pkg::CYC_MEM && io_wait_reg == 3'h0)) begin
					state_next = sbh_pkg::ST_DATA;
				end else begin
					state_next = sbh_pkg::ST_WAIT;
				end
			end
			sbh_pkg::ST_WAIT: begin
				if (wait_cnt_reg == 3'h1) begin
					state_next = sbh_pkg::ST_DATA;
				end
			end
			sbh_pkg::ST_DATA: begin
				if (refresh_en_reg && cur_reg.fetch && cur_reg.kind == sbh_pkg::CYC_MEM) begin
					state_next = sbh_pkg::ST_REFR;
				end else begin
					state_next = sbh_pkg::ST_IDLE;
				end
			end
			sbh_pkg::ST_REFR: state_next = sbh_pkg::ST_IDLE;
			default: state_next = sbh_pkg::ST_IDLE;
		endcase
		// supply fault aborts any cycle
		if (fault_reg) begin
			state_next = sbh_pkg::ST_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= sbh_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// request capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_reg <= '0;
			phys_reg <= 20'h00000;
			hit_reg <= 2'h0;
		end else if (take) begin
			cur_reg <= cpu_req;
			phys_reg <= phys_sel;
			hit_reg <= hit_calc;
		end
	end

	// wait counter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_cnt_reg <= 3'h0;
		end else if (state_reg == sbh_pkg::ST_ADDR) begin
			if (cur_reg.kind == sbh_pkg::CYC_MEM) begin
				wait_cnt_reg <= {1'b0, mem_wait_reg};
			end else begin
				wait_cnt_reg <= io_wait_reg;
			end
		end else if (state_reg == sbh_pkg::ST_WAIT) begin
			wait_cnt_reg <= 3'(wait_cnt_reg - 3'h1);
		end
	end

	// refresh row counter advances once per refresh strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			refresh_row_reg <= 8'h00;
		end else if (state_reg == sbh_pkg::ST_REFR) begin
			refresh_row_reg <= 8'(refresh_row_reg + 8'h01);
		end
	end

	// backplane pin values for the coming cycle, registered so pins never glitch
	always_comb begin
		sbh_pkg::sbh_req_t src;
		logic [19:0] src_pa;
		logic [1:0] src_hit;
		logic is_mem;
		logic on_board;
		// captured copies load at the take edge itself, too late for the address phase
		src = take ? cpu_req : cur_reg;
		src_pa = take ? phys_sel : phys_reg;
		src_hit = take ? hit_calc : hit_reg;
		is_mem = src.kind == sbh_pkg::CYC_MEM;
		on_board = |src_hit;
		bp_next = '0;
		bp_next.data_oe_n = 1'b1;
		bp_next.mem_rq_n = 1'b1;
		bp_next.io_rq_n = 1'b1;
		bp_next.rd_n = 1'b1;
		bp_next.wr_n = 1'b1;
		bp_next.mem_sync_n = 1'b1;
		bp_next.refresh_n = 1'b1;
		bp_next.intack_n = 1'b1;
		bp_next.sock_cs_n = 2'h3;
		bp_next.memex = 1'b0;
		bp_next.ioexp = 1'b0;
		case (state_next)
			sbh_pkg::ST_ADDR, sbh_pkg::ST_WAIT, sbh_pkg::ST_DATA: begin
				bp_next.addr = src_pa[15:0];
				bp_next.mem_rq_n = !is_mem;
				bp_next.io_rq_n = is_mem;
				bp_next.intack_n = src.kind != sbh_pkg::CYC_INTACK;
				bp_next.sock_cs_n = ~src_hit;
				if (state_next == sbh_pkg::ST_ADDR) begin
					// upper bits on data lines 0-3
					if (is_mem) begin
						bp_next.data = {4'h0, src_pa[19:16]};
						bp_next.data_oe_n = 1'b0;
						// sync low here, rising edge latches
						bp_next.mem_sync_n = 1'b0;
					end
				end else if (src.write) begin
					bp_next.data = src.wdata;
					bp_next.data_oe_n = 1'b0;
					// write strobe blocked on supply fault
					bp_next.wr_n = fault_reg;
				end else begin
					// acknowledge reads vector byte from card
					bp_next.rd_n = src.kind == sbh_pkg::CYC_INTACK;
				end
				// on-board socket reads drive the backplane read strobe low from the address phase on
				if (on_board && !src.write) begin
					bp_next.rd_n = 1'b0;
				end
			end
			sbh_pkg::ST_REFR: begin
				bp_next.addr = {8'h00, refresh_row_reg};
				bp_next.mem_rq_n = 1'b0;
				bp_next.refresh_n = 1'b0;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bp_out <= '{addr: 16'h0000, data: 8'h00, data_oe_n: 1'b1, mem_rq_n: 1'b1,
				io_rq_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, mem_sync_n: 1'b1, refresh_n: 1'b1,
				intack_n: 1'b1, sock_cs_n: 2'h3, memex: 1'b0, ioexp: 1'b0};
		end else begin
			bp_out <= bp_next;
		end
	end

	// answer to the processor; read data sampled from the synchronised bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_resp <= '0;
		end else begin
			cpu_resp.done <= 1'b0;
			if (take && io_internal) begin
				// internal block answers without a backplane cycle
				cpu_resp.done <= 1'b1;
				cpu_resp.internal_io <= 1'b1;
				cpu_resp.socket_hit <= 1'b0;
				cpu_resp.rdata <= 8'h00;
			end else if (state_reg == sbh_pkg::ST_DATA && !fault_reg) begin
				cpu_resp.done <= 1'b1;
				cpu_resp.internal_io <= 1'b0;
				cpu_resp.socket_hit <= |hit_reg;
				cpu_resp.rdata <= cur_reg.write ? 8'h00 : din_reg;
			end
		end
	end

endmodule // sbh_host_if

`default_nettype wire

// ===== testbench/sbh_host_if_checker.sv
// Purpose: assertions on the backplane host interface ports
// Assumes: one clock; control register shadowed from apb writes
// Notes: wait counts are measured from the take edge
`timescale 1ns/1ps
`default_nettype none
module sbh_host_if_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// processor port
	input wire sbh_pkg::sbh_req_t cpu_req,
	input wire logic cpu_ready,
	input wire sbh_pkg::sbh_resp_t cpu_resp,
	// pins
	input wire logic timer_toggle_output,
	input wire logic timer_output_pin,
	input wire sbh_pkg::sbh_bp_t bp_out,
	input wire logic supply_fault,
	input wire logic sys_reset_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [1:0] mw;
	logic [2:0] iw;
	logic ref_en;
	logic timer_toggle_output_en;
	logic [3:0] cnt;
	logic is_mem;
	logic [15:0] la;
	// io wait clamped as the design stores it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mw <= sbh_pkg::RST_MEM_WAIT;
			iw <= sbh_pkg::RST_IO_WAIT;
			ref_en <= sbh_pkg::RST_REFRESH_EN;
			timer_toggle_output_en <= sbh_pkg::RST_TIMER_TOGGLE_OUTPUT_EN;
		end else if (psel && penable && pwrite && paddr == sbh_pkg::OFF_CTRL) begin
			mw <= pwdata[1:0];
			iw <= (pwdata[6:4] > sbh_pkg::IO_WAIT_MAX) ? sbh_pkg::IO_WAIT_MAX : pwdata[6:4];
			ref_en <= pwdata[8];
			timer_toggle_output_en <= pwdata[9];
		end
	end
	// saturates so an idle bus never wraps into a false match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 4'hf;
			is_mem <= 1'b0;
			la <= 16'h0000;
		end else if (cpu_ready && cpu_req.valid) begin
			cnt <= 4'h0;
			is_mem <= cpu_req.kind == sbh_pkg::CYC_MEM;
			la <= cpu_req.addr;
		end else if (cnt != 4'hf) begin
			cnt <= cnt + 4'h1;
		end
	end
	sequence s_addr_phase;
		!bp_out.mem_sync_n && !bp_out.data_oe_n;
	endsequence
	sequence s_refresh;
		!bp_out.mem_rq_n ##1 bp_out.refresh_n;
	endsequence
	property p_memex;
		bp_out.memex == 1'b0;
	endproperty
	property p_ioexp;
		bp_out.ioexp == 1'b0;
	endproperty
	property p_upper_drive;
		!bp_out.mem_sync_n |-> !bp_out.data_oe_n && !bp_out.data[3];
	endproperty
	property p_upper_once;
		s_addr_phase |=> bp_out.mem_sync_n;
	endproperty
	property p_bit18;
		s_addr_phase and timer_toggle_output_en |-> !bp_out.data[2];
	endproperty
	property p_timer_pin;
		timer_output_pin == $past(timer_toggle_output && timer_toggle_output_en);
	endproperty
	property p_low_addr;
		s_addr_phase |-> bp_out.addr[11:0] == la[11:0];
	endproperty
	property p_io_addr;
		!bp_out.io_rq_n && bp_out.intack_n |-> bp_out.addr == la;
	endproperty
	property p_mem_wait;
		cpu_resp.done && is_mem |-> cnt == 4'h2 + {2'h0, mw};
	endproperty
	property p_io_wait;
		cpu_resp.done && !is_mem && !cpu_resp.internal_io |-> cnt == 4'h2 + {1'h0, iw};
	endproperty
	property p_internal;
		cpu_resp.done && cpu_resp.internal_io |-> cnt == 4'h0;
	endproperty
	property p_refresh;
		$fell(bp_out.refresh_n) |-> ref_en ##0 s_refresh;
	endproperty
	property p_fault;
		supply_fault [*4] |-> !sys_reset_n && bp_out.wr_n;
	endproperty
	a_memex: assert property (p_memex) else $error("memex driven");
	a_ioexp: assert property (p_ioexp) else $error("ioexp driven");
	a_upper_drive: assert property (p_upper_drive) else $error("upper bits bad");
	a_upper_once: assert property (p_upper_once) else $error("sync too long");
	a_bit18: assert property (p_bit18) else $error("bit 18 live");
	a_timer_pin: assert property (p_timer_pin) else $error("timer pin wrong");
	a_low_addr: assert property (p_low_addr) else $error("low address wrong");
	a_io_addr: assert property (p_io_addr) else $error("io address wrong");
	a_mem_wait: assert property (p_mem_wait) else $error("memory waits wrong");
	a_io_wait: assert property (p_io_wait) else $error("io waits wrong");
	a_internal: assert property (p_internal) else $error("internal io slow");
	a_refresh: assert property (p_refresh) else $error("refresh wrong");
	a_fault: assert property (p_fault) else $error("fault not held");
endmodule // sbh_host_if_checker
bind sbh_host_if sbh_host_if_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .cpu_req(cpu_req),
	.cpu_ready(cpu_ready), .cpu_resp(cpu_resp), .timer_toggle_output(timer_toggle_output),
	.timer_output_pin(timer_output_pin), .bp_out(bp_out), .supply_fault(supply_fault),
	.sys_reset_n(sys_reset_n));
`default_nettype wire

// ===== testbench/sbh_card_model.sv
// Purpose: backplane memory and io card model
// Assumes: card answers reads with a pattern of the address
// Notes: undriven lines toggle so stale data never looks valid
`timescale 1ns/1ps
`default_nettype none
module sbh_card_model #(
	parameter logic [7:0] VEC = 8'h3c
) (
	// clock
	input wire logic pclk,
	// backplane
	input wire sbh_pkg::sbh_bp_t bp,
	output logic [7:0] data_in,
	// addresses seen
	output logic [19:0] mem_addr,
	output logic [15:0] io_addr
);
	logic [7:0] last = 8'h00;
	logic oe;
	always @(posedge pclk) begin
		if (!bp.mem_sync_n) mem_addr <= {bp.data[3:0], bp.addr};
		if (!bp.io_rq_n) io_addr <= bp.addr;
		last <= data_in;
	end
	assign oe = bp.wr_n && bp.refresh_n && !(bp.mem_rq_n && bp.io_rq_n);
	assign data_in = !bp.data_oe_n ? bp.data : !oe ? ~last : !bp.intack_n ? VEC : bp.addr[7:0] ^ 8'h5a;
endmodule // sbh_card_model
`default_nettype wire

// ===== testbench/test_std_bus_host_address_interface.sv
// Purpose: self-checking bench for the backplane host interface
// Assumes: card model answers reads from the address lines
// Notes: reads use two or more waits so the synchroniser sees card data
`timescale 1ns/1ps
`default_nettype none
module test_std_bus_host_address_interface;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cpu_ready;
	logic tog = 1'b0;
	logic tpin;
	logic fault = 1'b0;
	logic srst_n;
	sbh_pkg::sbh_req_t req = '0;
	sbh_pkg::sbh_resp_t resp;
	sbh_pkg::sbh_bp_t bp;
	logic [7:0] din;
	logic [19:0] maddr;
	logic [15:0] iaddr;
	logic [31:0] rv;
	logic err;
	int k;
	int refs = 0;
	int miscompares = 0;
	int compares = 0;
	always #50 pclk = ~pclk;
	always @(negedge pclk) if (bp.refresh_n === 1'b0) refs++;
	sbh_host_if uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_req(req), .cpu_ready(cpu_ready), .cpu_resp(resp),
		.timer_toggle_output(tog), .timer_output_pin(tpin), .bp_out(bp), .bp_data_in(din),
		.supply_fault(fault), .sys_reset_n(srst_n));
	sbh_card_model card (.pclk(pclk), .bp(bp), .data_in(din), .mem_addr(maddr), .io_addr(iaddr));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request held until the edge that samples pready high; data taken there
		for (n = 0; n < 50; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rv = prdata;
		err = pslverr;
		if (pready !== 1'b1) miscompares++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cyc(input sbh_pkg::sbh_kind_t kd, input logic w, f, input logic [15:0] a);
		@(posedge pclk);
		req <= '{valid: 1'b1, kind: kd, write: w, fetch: f, dma: w, addr: a, wdata: 8'h96};
		@(negedge pclk);
		for (int n = 0; n < 50 && cpu_ready !== 1'b1; n++) @(negedge pclk);
		@(posedge pclk);
		req.valid <= 1'b0;
		for (k = 0; k < 50; k++) begin
			@(negedge pclk);
			if (resp.done === 1'b1) break;
		end
	endtask
	task automatic t_reset;
		logic [31:0] exp [4] = '{32'h0000_00ff, 32'h0000_0163, 32'h0, 32'h0000_2200};
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			check("reset value", rv, exp[i]);
		end
		apb(1'b1, 8'h14, 32'hffff_ffff);
		check("unmapped error", 32'(err), 32'h1);
		apb(1'b0, 8'h14, 32'h0);
		check("unmapped read", rv, 32'h0);
		apb(1'b1, sbh_pkg::OFF_SOCKET, 32'h0000_3030);
		$display("test reset done");
	endtask
	task automatic t_map;
		logic [15:0] la [4] = '{16'h1abc, 16'h5abc, 16'hd123, 16'hd123};
		logic [19:0] pa [4] = '{20'h01abc, 20'h25abc, 20'h7d123, 20'h3d123};
		tog <= 1'b1;
		apb(1'b1, sbh_pkg::OFF_MMU, 32'h00f0_20c4);
		check("timer pin", 32'(tpin), 32'h0);
		for (int i = 0; i < 4; i++) begin
			if (i == 3) apb(1'b1, sbh_pkg::OFF_CTRL, 32'h0000_0363);
			cyc(sbh_pkg::CYC_MEM, 1'b0, 1'b0, la[i]);
			check("physical", 32'(maddr), 32'(pa[i]));
			check("read data", 32'(resp.rdata), 32'(la[i][7:0] ^ 8'h5a));
		end
		check("timer pin", 32'(tpin), 32'h1);
		$display("test map done");
	endtask
	task automatic t_waits;
		for (int w = 0; w < 8; w++) begin
			apb(1'b1, sbh_pkg::OFF_CTRL, {23'h0, 1'b1, 1'b0, w[2:0], 2'h0, w[1:0]});
			cyc(sbh_pkg::CYC_MEM, 1'b1, 1'b0, 16'h1000);
			check("memory waits", k, 2 + w % 4);
			cyc(sbh_pkg::CYC_IO, 1'b1, 1'b0, 16'ha5c0 + 16'(w));
			check("io waits", k, 2 + (w > 6 ? 6 : w));
			check("io address", 32'(iaddr), 32'(16'ha5c0 + 16'(w)));
		end
		$display("test waits done");
	endtask
	task automatic t_io;
		logic [15:0] a [3] = '{16'h1240, 16'h127f, 16'h1280};
		apb(1'b1, sbh_pkg::OFF_IOBASE, 32'h0000_1240);
		for (int i = 0; i < 3; i++) begin
			cyc(sbh_pkg::CYC_IO, 1'b0, 1'b0, a[i]);
			check("internal io", 32'(resp.internal_io), 32'(i < 2));
			check("io latency", k, i < 2 ? 0 : 8);
		end
		$display("test io done");
	endtask
	task automatic t_refresh;
		for (int e = 1; e >= 0; e--) begin
			apb(1'b1, sbh_pkg::OFF_CTRL, {23'h0, e[0], 8'h33});
			refs = 0;
			cyc(sbh_pkg::CYC_MEM, 1'b0, 1'b1, 16'h1000);
			repeat (3) @(negedge pclk);
			check("refreshes", refs, e * sbh_pkg::REFRESH_CYCLES);
		end
		$display("test refresh done");
	endtask
	task automatic t_socket;
		logic [31:0] cfg [4] = '{32'h3001, 32'h3001, 32'h3020, 32'h3020};
		logic [15:0] a [4] = '{16'h2010, 16'h1010, 16'h3010, 16'h4010};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, sbh_pkg::OFF_SOCKET, cfg[i]);
			cyc(sbh_pkg::CYC_MEM, !i[0], 1'b0, a[i]);
			check("socket hit", 32'(resp.socket_hit), 32'(!i[0]));
		end
		cyc(sbh_pkg::CYC_INTACK, 1'b0, 1'b0, 16'h00ff);
		check("vector", 32'(resp.rdata), 32'h3c);
		$display("test socket done");
	endtask
	task automatic t_fault;
		@(posedge pclk);
		fault <= 1'b1;
		repeat (4) @(negedge pclk);
		check("held in reset", {30'h0, srst_n, cpu_ready}, 32'h0);
		@(posedge pclk);
		fault <= 1'b0;
		for (k = 0; k < 20 && srst_n !== 1'b1; k++) @(negedge pclk);
		check("reset released", 32'(srst_n), 32'h1);
		$display("test fault done");
	endtask
	task automatic complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_reset;
		t_map;
		t_waits;
		t_io;
		t_refresh;
		t_socket;
		t_fault;
		complete_run;
	end
	// a hang is cut short well past the few hundred cycles the tests take
	initial begin
		#2000000;
		miscompares++;
		complete_run;
	end
endmodule // test_std_bus_host_address_interface
`default_nettype wire
